// ### verilog/pfm_pkg.sv
// Package for the pin function multiplexer: selector codes, pin indices,
// reset values and the packed carriers shared by the design files.
// Assumes a single system clock domain; no imports are used anywhere.
package pfm_pkg;

  // Number of multiplexed pins and selector width.
  localparam int NUM_PINS = 10;
  localparam int SEL_W = 2;
  localparam int PORT_W = 16;
  localparam int TRIG_W = 2;

  // Selector encodings; function #1 is the reset state of every pin.
  localparam logic [1:0] SEL_FN1 = 2'h0;
  localparam logic [1:0] SEL_FN2 = 2'h1;
  localparam logic [1:0] SEL_FN3 = 2'h2;

  // Pin indices, numbered by the rapid port bit each pin carries.
  localparam int PIN_SCLK0 = 0;
  localparam int PIN_HOST_TWOWIRE_DATA_PIN = 1;
  localparam int PIN_MCLK = 2;
  localparam int PIN_MDAT = 3;
  localparam int PIN_WAKE = 4;
  localparam int PIN_DLYA = 5;
  localparam int PIN_AN0 = 6;
  localparam int PIN_AN1 = 7;
  localparam int PIN_DLYB = 8;
  localparam int PIN_DBG = 9;

  // Wake trigger encodings.
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_HIGH = 2'h2;
  localparam logic [1:0] TRIG_LOW = 2'h3;

  // Rapid port operation codes.
  typedef enum logic [1:0] {PFM_OP_WRITE, PFM_OP_SET, PFM_OP_CLR,
    PFM_OP_TOG} pfm_op_t;

  // Interrupt priority of the wake input.
  localparam logic [2:0] WAKE_PRIO = 3'h7;

  // Port value after reset.
  localparam logic [15:0] PORT_RST = 16'h0000;

  // Host interface chosen at boot.
  typedef enum logic {PFM_HOST_SPI, PFM_HOST_TWI} pfm_host_t;

  // Pad bundle for all multiplexed pins.
  typedef struct packed {
    logic [9:0] o;
    logic [9:0] oe;
  } pfm_pad_t;

  // Processor request to the rapid port.
  typedef struct packed {
    logic vld;
    pfm_op_t op;
    logic [15:0] data;
  } pfm_port_req_t;

endpackage

// ### verilog/pfm_rapid_port.sv
// Rapid I/O port: a 16-bit register with single-cycle write, set, clear
// and toggle operations. Assumes requests come from logic on clk.
`timescale 1ns/1ps

module pfm_rapid_port #(
  parameter int WIDTH = pfm_pkg::PORT_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Request and state.
  input wire pfm_pkg::pfm_port_req_t req,
  output logic [WIDTH-1:0] port_q
);

  logic [WIDTH-1:0] port_ff;
  logic [WIDTH-1:0] nxt_port;

  ////////////////////////////////////////////////////////////////////////
  // Next value by operation; one cycle for every operation.
  always_comb
  begin
    nxt_port = port_ff;
    if (req.vld)
    begin
      unique case (req.op)
        pfm_pkg::PFM_OP_WRITE: nxt_port = req.data[WIDTH-1:0];
        pfm_pkg::PFM_OP_SET: nxt_port = port_ff | req.data[WIDTH-1:0];
        pfm_pkg::PFM_OP_CLR: nxt_port = port_ff & ~req.data[WIDTH-1:0];
        pfm_pkg::PFM_OP_TOG: nxt_port = port_ff ^ req.data[WIDTH-1:0];
      endcase
    end
  end

  // Port register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      port_ff <= pfm_pkg::PORT_RST[WIDTH-1:0];
    else if (ce)
      port_ff <= nxt_port;
  end

  assign port_q = port_ff;

  // A set operation must raise the requested bits on the next edge.
  property p_port_set;
    @(posedge clk) disable iff (!nrst)
      (ce && req.vld && req.op == pfm_pkg::PFM_OP_SET) |=>
        ((port_ff & $past(req.data[WIDTH-1:0])) ==
          $past(req.data[WIDTH-1:0]));
  endproperty
  a_port_set: assert property (p_port_set)
    else $error("rapid port set did not take");

  // A toggle must invert exactly the requested bits.
  property p_port_tog;
    @(posedge clk) disable iff (!nrst)
      (ce && req.vld && req.op == pfm_pkg::PFM_OP_TOG) |=>
        (port_ff == ($past(port_ff) ^ $past(req.data[WIDTH-1:0])));
  endproperty
  a_port_tog: assert property (p_port_tog)
    else $error("rapid port toggle wrong");

endmodule // pfm_rapid_port

// ### verilog/pfm_wake_detect.sv
// Wake input trigger detector: rising, falling, high or low level.
// Assumes the wake level is already synchronised to clk.
`timescale 1ns/1ps

module pfm_wake_detect (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Trigger selection and input.
  input wire logic en,
  input wire logic [1:0] trig,
  input wire logic lvl,
  // Request out.
  output logic hit
);

  logic prev_ff;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////
  // Edge terms and trigger selection.
  assign rise = lvl & ~prev_ff;
  assign fall = ~lvl & prev_ff;
  assign hit = en & ((trig == pfm_pkg::TRIG_RISE & rise) |
    (trig == pfm_pkg::TRIG_FALL & fall) |
    (trig == pfm_pkg::TRIG_HIGH & lvl) |
    (trig == pfm_pkg::TRIG_LOW & ~lvl));

  // Previous level resets high, as the pad synchronisers do, so that no
  // false rising edge follows the release of reset.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_ff <= 1'b1;
    else if (ce)
      prev_ff <= lvl;
  end

endmodule // pfm_wake_detect

// ### verilog/pfm_pin_mux.sv
// Pin function multiplexer with boot-pin sampling, reset pin control,
// wake interrupt and host response flag. Assumes one clock, clk, and
// that peripherals sit on clk; pad inputs are synchronised here.
//
// Operation
// - Every multiplexed pin leaves reset with its first function active.
// - Firmware may change each pin's function separately after reset.
// - The rapid port is 16 bits with one-cycle write, set, clear, toggle.
// - The slave-select pin sampled at boot picks SPI (low) or TWI (high).
// - The debug pin sampled at boot picks normal run (high) or debug (low).
// - In debug the debug pin works as a two-way single-wire port.
// - The reset pin is open drain, input at start, drivable on request.
// - The wake input triggers on rise, fall, high or low as programmed.
// - The wake request is delivered at priority level seven.
// - The response flag output tells the host a reply is ready.
// - The analog pair is differential, second pin positive, at the rate.
// - The delay block outputs drive their pins when selected.
// - Timer channels 0 and 1 use their pins when selected.
// - Each shared pin has one rapid port bit; master bus shares SPI pins.
// - Host slave pins stay routed regardless of processor sleep.
`timescale 1ns/1ps

module pfm_pin_mux #(
  parameter int NPIN = pfm_pkg::NUM_PINS
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Selector write port from the integration unit.
  input wire logic sel_wr,
  input wire logic [3:0] sel_idx,
  input wire logic [1:0] sel_data,
  // Processor rapid port access.
  input wire pfm_pkg::pfm_port_req_t port_req,
  output logic [15:0] port_rd,
  // Multiplexed pads.
  input wire logic [9:0] pad_in,
  output pfm_pkg::pfm_pad_t pad,
  // Reset pin, open drain.
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic reset_drive_en,
  input wire logic reset_drive,
  output logic ext_reset_req,
  // Boot state.
  input wire logic boot_done,
  output logic host_is_twi,
  output logic debug_session,
  // Debug single-wire port.
  input wire logic dbg_out,
  input wire logic dbg_oe,
  output logic dbg_in,
  // Host slave peripherals.
  output logic host_clk,
  output logic host_sdi,
  output logic host_ss,
  input wire logic host_sdo,
  input wire logic host_sdo_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  output logic host_sda_i,
  // Master two-wire peripheral.
  input wire logic mst_scl_oe,
  input wire logic mst_sda_oe,
  output logic mst_scl_i,
  output logic mst_sda_i,
  // Wake interrupt.
  input wire logic wake_en,
  input wire logic [1:0] wake_trig,
  output logic wake_irq,
  output logic [2:0] wake_prio,
  // Response flag, delay block, timer, analog.
  input wire logic resp_ready,
  input wire logic dly_a,
  input wire logic dly_b,
  input wire logic [1:0] tmr_o,
  input wire logic [1:0] tmr_oe,
  output logic [1:0] tmr_i,
  output logic adc_diff_en,
  input wire logic rate_tick,
  output logic adc_start
);

  logic [1:0] sel_ff [NPIN];
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic drv_d1_ff;
  logic drv_d2_ff;
  logic boot_ff;
  logic twi_ff;
  logic dbg_ff;
  logic [9:0] pad_o_ff;
  logic [9:0] pad_oe_ff;
  logic [9:0] nxt_pad_o;
  logic [9:0] nxt_pad_oe;
  logic [15:0] port_q;
  logic wake_hit;
  logic adc_start_ff;

  // Helper that tests a pin's selector.
  function automatic logic is_sel(input logic [1:0] s, input logic [1:0] c);
    return s == c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per-pin selectors; a write takes effect for input routing on the edge
  // that stores it, and at the output pads one edge later.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NPIN; i++)
        sel_ff[i] <= pfm_pkg::SEL_FN1;
    end
    else if (ce && sel_wr && int'(sel_idx) < NPIN)
      sel_ff[sel_idx] <= sel_data;
  end

  // Two-stage synchronisers for every pad input.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= 10'h3ff;
      sync2_ff <= 10'h3ff;
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= 1'b1;
      drv_d1_ff <= 1'b0;
      drv_d2_ff <= 1'b0;
    end
    else if (ce)
    begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      rst_s1_ff <= reset_pin_in;
      rst_s2_ff <= rst_s1_ff;
      drv_d1_ff <= reset_pin_oe;
      drv_d2_ff <= drv_d1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot sampling: captured once, at the first enabled edge with boot_done.
  // The pins are read from the synchronised copies, never at reset.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_ff <= 1'b0;
      twi_ff <= 1'b0;
      dbg_ff <= 1'b0;
    end
    else if (ce && boot_done && !boot_ff)
    begin
      boot_ff <= 1'b1;
      twi_ff <= sync2_ff[pfm_pkg::PIN_MDAT];
      dbg_ff <= ~sync2_ff[pfm_pkg::PIN_DBG];
    end
  end

  assign host_is_twi = twi_ff;
  assign debug_session = dbg_ff;

  ////////////////////////////////////////////////////////////////////////
  // Rapid port and wake detection.
  pfm_rapid_port #(
    .WIDTH(pfm_pkg::PORT_W)
  ) u_port (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .req(port_req),
    .port_q(port_q)
  );

  // Reads show pad levels on input pins in the low ten bits.
  assign port_rd = {port_q[15:10], port_q[9:0] & pad_oe_ff |
    sync2_ff & ~pad_oe_ff};

  pfm_wake_detect u_wake (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .en(wake_en & is_sel(sel_ff[pfm_pkg::PIN_WAKE], pfm_pkg::SEL_FN2)),
    .trig(wake_trig),
    .lvl(sync2_ff[pfm_pkg::PIN_WAKE]),
    .hit(wake_hit)
  );
  assign wake_irq = wake_hit;
  assign wake_prio = pfm_pkg::WAKE_PRIO;

  ////////////////////////////////////////////////////////////////////////
  // Output routing per pin from the selectors.
  always_comb
  begin
    nxt_pad_o = port_q[9:0];
    nxt_pad_oe = 10'h000;
    for (int i = 0; i < NPIN; i++)
      nxt_pad_oe[i] = 1'b0;
    // Host pins: slave bus on function one, port on two, undriven on three.
    nxt_pad_o[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN] = 1'b0;
    nxt_pad_oe[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN] = is_sel(sel_ff[1], pfm_pkg::SEL_FN1) ?
      host_sda_oe : is_sel(sel_ff[1], pfm_pkg::SEL_FN2);
    if (is_sel(sel_ff[1], pfm_pkg::SEL_FN2))
      nxt_pad_o[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN] = port_q[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN];
    nxt_pad_oe[pfm_pkg::PIN_SCLK0] = is_sel(sel_ff[0], pfm_pkg::SEL_FN2);
    // Pin 2: port, master clock (open drain) or SPI data out.
    unique case (sel_ff[pfm_pkg::PIN_MCLK])
      pfm_pkg::SEL_FN2:
      begin
        nxt_pad_o[pfm_pkg::PIN_MCLK] = 1'b0;
        nxt_pad_oe[pfm_pkg::PIN_MCLK] = mst_scl_oe;
      end
      pfm_pkg::SEL_FN3:
      begin
        nxt_pad_o[pfm_pkg::PIN_MCLK] = host_sdo;
        nxt_pad_oe[pfm_pkg::PIN_MCLK] = host_sdo_oe;
      end
      default: nxt_pad_oe[pfm_pkg::PIN_MCLK] = 1'b1;
    endcase
    // Pin 3: port, master data (open drain) or slave select input. The
    // port leaves it undriven until boot, so the outside level is sampled.
    unique case (sel_ff[pfm_pkg::PIN_MDAT])
      pfm_pkg::SEL_FN2:
      begin
        nxt_pad_o[pfm_pkg::PIN_MDAT] = 1'b0;
        nxt_pad_oe[pfm_pkg::PIN_MDAT] = mst_sda_oe;
      end
      pfm_pkg::SEL_FN3: nxt_pad_oe[pfm_pkg::PIN_MDAT] = 1'b0;
      default: nxt_pad_oe[pfm_pkg::PIN_MDAT] = boot_ff;
    endcase
    // Pin 4: port output or wake input.
    nxt_pad_oe[pfm_pkg::PIN_WAKE] = is_sel(sel_ff[4], pfm_pkg::SEL_FN1);
    // Pin 5: port, delay block A, or response flag.
    unique case (sel_ff[pfm_pkg::PIN_DLYA])
      pfm_pkg::SEL_FN2: nxt_pad_o[pfm_pkg::PIN_DLYA] = dly_a;
      pfm_pkg::SEL_FN3: nxt_pad_o[pfm_pkg::PIN_DLYA] = resp_ready;
      default: nxt_pad_o[pfm_pkg::PIN_DLYA] = port_q[pfm_pkg::PIN_DLYA];
    endcase
    nxt_pad_oe[pfm_pkg::PIN_DLYA] = 1'b1;
    // Pins 6 and 7: port, analog input (no drive) or timer channel.
    for (int k = 0; k < 2; k++)
    begin
      unique case (sel_ff[pfm_pkg::PIN_AN0 + k])
        pfm_pkg::SEL_FN2: nxt_pad_oe[pfm_pkg::PIN_AN0 + k] = 1'b0;
        pfm_pkg::SEL_FN3:
        begin
          nxt_pad_o[pfm_pkg::PIN_AN0 + k] = tmr_o[k];
          nxt_pad_oe[pfm_pkg::PIN_AN0 + k] = tmr_oe[k];
        end
        default: nxt_pad_oe[pfm_pkg::PIN_AN0 + k] = 1'b1;
      endcase
    end
    // Pin 8: port or delay block B.
    nxt_pad_oe[pfm_pkg::PIN_DLYB] = 1'b1;
    if (is_sel(sel_ff[pfm_pkg::PIN_DLYB], pfm_pkg::SEL_FN2))
      nxt_pad_o[pfm_pkg::PIN_DLYB] = dly_b;
    // Pin 9: debug wire in function one, port in function two.
    if (is_sel(sel_ff[pfm_pkg::PIN_DBG], pfm_pkg::SEL_FN1))
    begin
      nxt_pad_o[pfm_pkg::PIN_DBG] = dbg_out;
      nxt_pad_oe[pfm_pkg::PIN_DBG] = dbg_ff & dbg_oe;
    end
    else
      nxt_pad_oe[pfm_pkg::PIN_DBG] = 1'b1;
  end

  // Pad outputs are registered to keep glitches off the pins.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pad_o_ff <= 10'h000;
      pad_oe_ff <= 10'h000;
    end
    else if (ce)
    begin
      pad_o_ff <= nxt_pad_o;
      pad_oe_ff <= nxt_pad_oe;
    end
  end

  assign pad.o = pad_o_ff;
  assign pad.oe = pad_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Input routing; host pins stay routed in every power state.
  assign host_clk = sync2_ff[pfm_pkg::PIN_SCLK0];
  assign host_sda_i = sync2_ff[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN];
  assign host_sdi = sync2_ff[pfm_pkg::PIN_HOST_TWOWIRE_DATA_PIN];
  assign host_ss = is_sel(sel_ff[3], pfm_pkg::SEL_FN3) ?
    sync2_ff[pfm_pkg::PIN_MDAT] : 1'b1;
  assign mst_scl_i = sync2_ff[pfm_pkg::PIN_MCLK];
  assign mst_sda_i = sync2_ff[pfm_pkg::PIN_MDAT];
  assign dbg_in = sync2_ff[pfm_pkg::PIN_DBG] & dbg_ff;
  assign tmr_i = sync2_ff[pfm_pkg::PIN_AN1:pfm_pkg::PIN_AN0];

  ////////////////////////////////////////////////////////////////////////
  // Analog pair: differential mode when both pins carry the analog
  // function; conversions start on the sample rate tick only.
  assign adc_diff_en = is_sel(sel_ff[6], pfm_pkg::SEL_FN2) &
    is_sel(sel_ff[7], pfm_pkg::SEL_FN2);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      adc_start_ff <= 1'b0;
    else if (ce)
      adc_start_ff <= rate_tick & adc_diff_en;
  end
  assign adc_start = adc_start_ff;

  ////////////////////////////////////////////////////////////////////////
  // Reset pin: input until firmware enables drive; drive only pulls low.
  // The request is ignored until boot finishes, as the pin must stay high.
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = reset_drive_en & reset_drive & boot_ff;
  // Our own drive is masked while it drains through the synchroniser, or
  // releasing the pin would read as an outside reset for two cycles.
  assign ext_reset_req = boot_ff & ~rst_s2_ff & ~reset_pin_oe &
    ~drv_d1_ff & ~drv_d2_ff;

  // Selector reset state holds the debug pin at function one.
  property p_sel_reset;
    @(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> sel_ff[pfm_pkg::PIN_DBG] == pfm_pkg::SEL_FN1;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("selector not at first function");

  // A selector write lands on the next edge.
  property p_sel_write;
    @(posedge clk) disable iff (!nrst)
      (ce && sel_wr && sel_idx == 4'h5) |=> sel_ff[5] == $past(sel_data);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("selector write lost");

  // Boot sample of the slave select decides the host interface.
  property p_boot_twi;
    @(posedge clk) disable iff (!nrst)
      (ce && boot_done && !boot_ff) |=>
        host_is_twi == $past(sync2_ff[pfm_pkg::PIN_MDAT]);
  endproperty
  a_boot_twi: assert property (p_boot_twi)
    else $error("host interface sample wrong");

  // Debug session follows a low mode pin at boot and then holds.
  property p_boot_dbg;
    @(posedge clk) disable iff (!nrst)
      (ce && boot_done && !boot_ff) |=>
        (debug_session == !$past(sync2_ff[pfm_pkg::PIN_DBG]))
        ##1 $stable(debug_session);
  endproperty
  a_boot_dbg: assert property (p_boot_dbg)
    else $error("debug mode sample wrong");

  // The debug wire is never driven outside a session.
  property p_dbg_drive;
    @(posedge clk) disable iff (!nrst)
      (ce && !dbg_ff && is_sel(sel_ff[9], pfm_pkg::SEL_FN1)) |=>
        !pad.oe[9];
  endproperty
  a_dbg_drive: assert property (p_dbg_drive)
    else $error("debug pin driven outside session");

  // The reset pin is only driven low, and never before boot.
  property p_rst_od;
    @(posedge clk) disable iff (!nrst)
      reset_pin_oe |-> (boot_ff && !reset_pin_out);
  endproperty
  a_rst_od: assert property (p_rst_od)
    else $error("reset pin drive illegal");

  // A high-level trigger raises the wake request while the pin is high.
  property p_wake_high;
    @(posedge clk) disable iff (!nrst)
      (wake_en && wake_trig == pfm_pkg::TRIG_HIGH &&
       sel_ff[4] == pfm_pkg::SEL_FN2 && sync2_ff[4]) |-> wake_irq;
  endproperty
  a_wake_high: assert property (p_wake_high)
    else $error("wake high level missed");

  // Response flag reaches the pin one edge after it rises.
  property p_resp_pin;
    @(posedge clk) disable iff (!nrst)
      (ce && sel_ff[5] == pfm_pkg::SEL_FN3 && resp_ready) |=> pad.o[5];
  endproperty
  a_resp_pin: assert property (p_resp_pin)
    else $error("response flag not on pin");

endmodule // pfm_pin_mux

// ### bench/pfm_far_end.sv
// Far-end model: the outside parts on the multiplexed pads and reset pin.
// Assumes the bench sets the outside levels; the device wins where it
// drives a pad, since the outside parts only hold weak levels there.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module pfm_far_end (
  // Device side.
  input wire pfm_pkg::pfm_pad_t pad,
  input wire logic reset_pin_oe,
  output logic [9:0] pad_in,
  output logic reset_pin_in,
  // Bench controls.
  input wire logic [9:0] ext_lvl,
  input wire logic ext_rst_low
);
  // Each pad shows the device level where it drives, else the outside one.
  // The bench keeps the boot pins steady through startup.
  assign pad_in = (pad.o & pad.oe) | (ext_lvl & ~pad.oe);
  // The reset line has a pull-up; the outside pulls only after startup.
  assign reset_pin_in = !(reset_pin_oe || ext_rst_low);
endmodule // pfm_far_end

// ### bench/test_pin_function_mux_boot_select.sv
// Self-checking bench for the pin function multiplexer, random and corner.
// Assumes the far-end model resolves every pad and the reset pin.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module test_pin_function_mux_boot_select;
  logic clk = 0, nrst = 0, ce = 1, sel_wr = 0, boot_done = 0;
  logic rate_tick = 0, reset_drive_en = 0, reset_drive = 0;
  logic dbg_out = 0, dbg_oe = 0, host_sda_oe = 0, mst_scl_oe = 0;
  logic mst_sda_oe = 0, wake_en = 0, resp_ready = 0, dly_a = 0, dly_b = 0;
  logic host_sdo = 0, host_sdo_oe = 0, host_sda_o = 0, ext_rst_low = 0;
  logic [3:0] sel_idx = 4'h0;
  logic [1:0] sel_data = 2'h0, wake_trig = 2'h0, tmr_o = 2'h0, tmr_oe = 2'h0;
  logic [9:0] ext_lvl = 10'h000, pad_in;
  logic [15:0] port_rd, exp_port = pfm_pkg::PORT_RST;
  pfm_pkg::pfm_port_req_t port_req = '0;
  pfm_pkg::pfm_pad_t pad;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, ext_reset_req;
  logic host_is_twi, debug_session, dbg_in, host_clk, host_sdi, host_ss;
  logic host_sda_i, mst_scl_i, mst_sda_i, wake_irq, adc_diff_en, adc_start;
  logic [2:0] wake_prio;
  logic [1:0] tmr_i;
  int fails = 0, checks = 0, cnt;
  integer seed = 32'haa6a_bca9;

  pfm_pin_mux pfm_pin_mux_i (.*);
  pfm_far_end pfm_far_end_i (.*);

  // Free-running clock at 4 ns.
  always #2 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  // Inputs always move 1 ns after an edge, so no race with the design.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A gap cycle follows each write so the strobe is never reassigned.
  task automatic sel(input int idx, input logic [1:0] code);
    sel_wr = 1;
    sel_idx = idx[3:0];
    sel_data = code;
    tick(1);
    sel_wr = 0;
    tick(1);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] op_res(input logic [15:0] q,
    input pfm_pkg::pfm_op_t op, input logic [15:0] d);
    case (op)
      pfm_pkg::PFM_OP_WRITE: return d;
      pfm_pkg::PFM_OP_SET: return q | d;
      pfm_pkg::PFM_OP_CLR: return q & ~d;
      default: return q ^ d;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    // Boot under every level pair on the slave-select and debug pins.
    for (int b = 0; b < 4; b++)
    begin
      nrst = 0;
      boot_done = 0;
      ext_lvl = {b[1], 5'h00, b[0], 3'h0};
      reset_drive_en = 1;
      reset_drive = 1;
      tick(4);
      chk("pad enables", 0, pad.oe);
      chk("port upper", 0, port_rd[15:10]);
      nrst = 1;
      tick(4);
      chk("reset drive early", 0, reset_pin_oe);
      boot_done = 1;
      tick(3);
      chk("host twi", b[0], host_is_twi);
      chk("debug session", !b[1], debug_session);
      chk("reset drive", 1, reset_pin_oe);
      chk("reset pin out", 0, reset_pin_out);
      chk("host select", 1, host_ss);
      chk("wake prio", pfm_pkg::WAKE_PRIO, wake_prio);
      ext_lvl[9] = 1;
      tick(3);
      chk("debug in", !b[1], dbg_in);
      dbg_oe = 1;
      tick(3);
      chk("debug drive", !b[1], pad.oe[9]);
      dbg_oe = 0;
    end
    tick(1);
    chk("self reset", 0, ext_reset_req);
    reset_drive = 0;
    tick(1);
    chk("reset release", 0, reset_pin_oe);
    repeat (3)
    begin
      chk("self release", 0, ext_reset_req);
      tick(1);
    end
    ext_rst_low = 1;
    tick(3);
    chk("outside reset", 1, ext_reset_req);
    ext_rst_low = 0;
    tick(4);
    chk("outside release", 0, ext_reset_req);
    $display("test boot and reset done");
    // All ten pins on their rapid bit, then the four ops in turn back to back, all-ones data first, then random.
    sel(0, pfm_pkg::SEL_FN2);
    sel(1, pfm_pkg::SEL_FN2);
    sel(9, pfm_pkg::SEL_FN2);
    for (int i = 0; i < 40; i++)
    begin
      port_req.vld = 1;
      port_req.op = pfm_pkg::pfm_op_t'(i[1:0]);
      port_req.data = (i < 4) ? 16'hffff : 16'($random(seed));
      exp_port = op_res(exp_port, port_req.op, port_req.data);
      tick(1);
      chk("port read", exp_port, port_rd);
    end
    // Clock enable low freezes the port against a standing request.
    ce = 0;
    tick(2);
    chk("frozen port", exp_port, port_rd);
    ce = 1;
    port_req.vld = 0;
    tick(1);
    chk("port pads", exp_port[9:0] & pad.oe, pad.o & pad.oe);
    $display("test rapid port done");
    // Every trigger kind, first disabled, then enabled.
    sel(pfm_pkg::PIN_WAKE, pfm_pkg::SEL_FN2);
    for (int k = 0; k < 8; k++)
    begin
      wake_en = k[2];
      wake_trig = k[1:0];
      ext_lvl[4] = k[0];
      tick(6);
      ext_lvl[4] = !k[0];
      cnt = 0;
      repeat (6)
      begin
        tick(1);
        cnt += wake_irq;
      end
      if (!k[1])
        chk("wake pulses", k[2], cnt);
      chk("wake level", k[2] & k[1], wake_irq);
    end
    sel(pfm_pkg::PIN_WAKE, pfm_pkg::SEL_FN1);
    tick(2);
    chk("wake off pin", 0, wake_irq);
    $display("test wake done");
    // Delay and timer functions follow their sources.
    sel(pfm_pkg::PIN_DLYA, pfm_pkg::SEL_FN2);
    sel(pfm_pkg::PIN_DLYB, pfm_pkg::SEL_FN2);
    sel(pfm_pkg::PIN_AN0, pfm_pkg::SEL_FN3);
    sel(pfm_pkg::PIN_AN1, pfm_pkg::SEL_FN3);
    for (int i = 0; i < 8; i++)
    begin
      {dly_a, dly_b, tmr_o, tmr_oe} = 6'($random(seed));
      {dbg_out, host_sda_oe, mst_scl_oe, mst_sda_oe} = 4'($random(seed));
      ext_lvl[7:6] = 2'($random(seed));
      tick(4);
      chk("delay a", {dly_a, 1'b1}, {pad.o[5], pad.oe[5]});
      chk("delay b", {dly_b, 1'b1}, {pad.o[8], pad.oe[8]});
      chk("timer oe", tmr_oe, pad.oe[7:6]);
      chk("timer out", tmr_o & tmr_oe, pad.o[7:6] & tmr_oe);
      chk("timer in", (tmr_o & tmr_oe) | (ext_lvl[7:6] & ~tmr_oe),
        tmr_i);
    end
    sel(pfm_pkg::PIN_DLYA, pfm_pkg::SEL_FN3);
    for (int i = 0; i < 2; i++)
    begin
      resp_ready = i[0];
      tick(3);
      chk("response flag", {i[0], 1'b1}, {pad.o[5], pad.oe[5]});
    end
    // Pins 0 and 1 on the slave two-wire bus, pins 2 and 3 alternating
    // between master two-wire and SPI; outside levels are random.
    sel(0, pfm_pkg::SEL_FN1);
    sel(1, pfm_pkg::SEL_FN1);
    for (int i = 0; i < 8; i++)
    begin
      {host_sdo, host_sdo_oe, host_sda_oe, mst_scl_oe, mst_sda_oe} =
        5'($random(seed));
      ext_lvl[3:0] = 4'($random(seed));
      sel(2, i[0] ? pfm_pkg::SEL_FN3 : pfm_pkg::SEL_FN2);
      sel(3, i[0] ? pfm_pkg::SEL_FN3 : pfm_pkg::SEL_FN2);
      tick(2);
      chk("host pins", {1'b0, host_sda_oe, 1'b0, ext_lvl[0]},
        {pad.o[1], pad.oe[1:0], host_clk});
      chk("host data", {2{ext_lvl[1] & !host_sda_oe}},
        {host_sda_i, host_sdi});
      chk("pin 2 drive", i[0] ? {host_sdo_oe, host_sdo & host_sdo_oe} :
        {mst_scl_oe, 1'b0}, {pad.oe[2], pad.o[2] & pad.oe[2]});
      chk("master clock", i[0] ? (ext_lvl[2] & !host_sdo_oe) |
        (host_sdo & host_sdo_oe) : ext_lvl[2] & !mst_scl_oe,
        mst_scl_i);
      chk("pin 3 drive", {!i[0] & mst_sda_oe, 1'b0},
        {pad.oe[3], pad.o[3] & pad.oe[3]});
      chk("master data", ext_lvl[3] & !(mst_sda_oe & !i[0]),
        mst_sda_i);
      chk("slave select", i[0] ? ext_lvl[3] : 1'b1, host_ss);
    end
    // Differential pair only when both analog pins are selected.
    chk("diff off", 0, adc_diff_en);
    sel(pfm_pkg::PIN_AN0, pfm_pkg::SEL_FN2);
    sel(pfm_pkg::PIN_AN1, pfm_pkg::SEL_FN2);
    chk("diff on", 1, adc_diff_en);
    cnt = 0;
    for (int i = 0; i < 12; i++)
    begin
      rate_tick = (i % 4 == 0);
      tick(1);
      cnt += adc_start;
    end
    chk("conversion starts", 3, cnt);
    $display("test pin functions done");
    close_out;
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule // test_pin_function_mux_boot_select
